//--- olp_pkg.sv
// constants shared by the loopback pattern player and its output fifo
package olp_pkg;

  // ***************************************************************
  // register offsets on the card register port
  // ***************************************************************
  localparam logic [7:0] OLP_OFS_ADDR_LOW  = 8'ha0;
  localparam logic [7:0] OLP_OFS_ADDR_HIGH = 8'ha4;
  localparam logic [7:0] OLP_OFS_READBACK  = 8'ha8;
  localparam logic [7:0] OLP_OFS_WRITE     = 8'hac;

  // ***************************************************************
  // field layout and reset values
  // ***************************************************************
  localparam int         OLP_ADDR_W        = 10;
  localparam int         OLP_HIGH_W        = 2;
  localparam int         OLP_LANE_W        = 2;
  localparam int         OLP_BYTE_W        = 8;
  localparam logic [7:0] OLP_RST_BYTE      = 8'h00;
  localparam logic [1:0] OLP_RST_HIGH      = 2'h0;

  // ***************************************************************
  // pattern memory geometry
  // ***************************************************************
  localparam int         OLP_WORDS         = 216;
  localparam int         OLP_WORD_W        = 32;
  localparam int         OLP_IDX_W         = 8;
  localparam logic [7:0] OLP_LAST_WORD     = 8'hd7;   // word 215
  localparam logic [9:0] OLP_ADDR_LIMIT    = 10'h360; // byte 864
  localparam int         OLP_TRAINS        = 3;

  // ***************************************************************
  // timing: one word slot of 22 ns at a 100 ns system clock
  // ***************************************************************
  localparam int         OLP_CLK_PERIOD_NS = 100;
  localparam int         OLP_WORD_NS       = 22;
  // longest time rounds down, but never below one cycle
  localparam int         OLP_WORD_CYCLES   =
    (OLP_WORD_NS / OLP_CLK_PERIOD_NS < 1) ? 1 : OLP_WORD_NS / OLP_CLK_PERIOD_NS;
  localparam int         OLP_FIFO_DEPTH    = 8;

  // playback sequencer states
  typedef enum logic [0:0] {
    OLP_TRAIN,
    OLP_GAP
  } olp_state_t;

endpackage : olp_pkg

//--- olp_stream_if.sv
// valid/ready stream carrier between the player and its fifo
`timescale 1ns/10ps
interface olp_stream_if #(
  parameter int WIDTH = 34
);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;

  // producer end
  modport src (output valid, output data, input ready);
  // consumer end
  modport snk (input valid, input data, output ready);
endinterface : olp_stream_if

//--- olp_fifo.sv
// synchronous fifo of flip-flops with valid/ready on both sides
`timescale 1ns/10ps
module olp_fifo #(
  parameter int WIDTH = 34,
  parameter int DEPTH = 8
) (
  // clock and control
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // fill and drain sides
  olp_stream_if.snk in_s,
  olp_stream_if.src out_s
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [CW-1:0]    count;
  logic             push;
  logic             pop;

  // honest flags straight from the occupancy count
  assign in_s.ready  = (count != FULL_CNT);
  assign out_s.valid = (count != '0);
  assign out_s.data  = store[rd_ptr];
  assign push        = ce && in_s.valid && in_s.ready;
  assign pop         = ce && out_s.valid && out_s.ready;

  // storage: no reset needed, contents are gated by the count
  always_ff @(posedge clk) begin
    if (push) begin
      store[wr_ptr] <= in_s.data;
    end
  end

  // pointers and count
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == LAST_PTR) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == LAST_PTR) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule : olp_fifo

//--- olp_loopback_pattern_player.sv
// loopback pattern player: byte-loaded pattern memory played out per bunch zero
`timescale 1ns/10ps

// Summary of operation
// - memory of 216 words by 32 bits
// - byte address 4w+k picks lane k
// - low address register, bits 7:0, read/write
// - high register keeps bits 1:0, ignores rest
// - address change fetches byte into readback
// - readback shows fetched byte, writes ignored
// - data register write stores byte at address
// - all pattern bytes zero after configuration
// - bytes may be loaded in any order
// - counter zeroed by bunch zero, holds in gap
// - words 0-215 played, three trains per period
// - gap keeps presenting word 215
// - strobe, first word, bunch zero generated here
// - playback runs from reset without start command
module olp_loopback_pattern_player
  import olp_pkg::*;
#(
  parameter int WORDS      = olp_pkg::OLP_WORDS,
  parameter int FIFO_DEPTH = olp_pkg::OLP_FIFO_DEPTH
) (
  // clock, reset, enable
  input  wire logic                               CLK_SYS,
  input  wire logic                               RESET,
  input  wire logic                               CLK_EN,
  // card register port
  input  wire logic [7:0]                         REG_ADDR,
  input  wire logic [olp_pkg::OLP_BYTE_W-1:0]     REG_WDATA,
  input  wire logic                               REG_WR,
  input  wire logic                               REG_RD,
  output logic      [olp_pkg::OLP_BYTE_W-1:0]     REG_RDATA,
  // beam timing inputs
  input  wire logic                               BUNCH_ZERO_MARKER_IN,
  input  wire logic                               ABORT_GAP_IN,
  // pattern output towards the transition cards
  input  wire logic                               PAT_READY,
  output logic      [olp_pkg::OLP_WORD_W-1:0]     PAT_DATA,
  output logic                                    PAT_STROBE,
  output logic                                    PAT_FIRST_WORD_MARKER,
  output logic                                    PAT_BUNCH_ZERO_MARKER
);

  import olp_pkg::*;

  // fifo element: the pattern word with its two markers on top
  localparam int ELEM_W = OLP_WORD_W + 2;
  // slot divider width; a 22 ns slot rounds to one 100 ns cycle
  localparam int DIV_W  = $clog2(OLP_WORD_CYCLES + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(OLP_WORD_CYCLES - 1);

  // ***************************************************************
  // register file
  // ***************************************************************
  // host-visible registers and the pending fetch
  logic [OLP_BYTE_W-1:0]  addr_low;
  logic [OLP_HIGH_W-1:0]  addr_high;
  logic [OLP_BYTE_W-1:0]  readback;
  logic                   fetch_pend;

  // byte address split into word index and lane
  logic [OLP_ADDR_W-1:0]  byte_addr;
  logic [OLP_IDX_W-1:0]   host_word;
  logic [OLP_LANE_W-1:0]  host_lane;
  logic                   host_in_range;

  // one-cycle write decodes
  logic                   wr_low;
  logic                   wr_high;
  logic                   wr_byte;

  // word index and byte lane from the byte address
  assign byte_addr     = {addr_high, addr_low};
  assign host_word     = byte_addr[OLP_ADDR_W-1:OLP_LANE_W];
  assign host_lane     = byte_addr[OLP_LANE_W-1:0];
  // there is no word past the last one, but the fetch mux would read
  // unknowns there, so this one test guards the store and the fetch
  // bytes past the last word are out of range
  assign host_in_range = (byte_addr < OLP_ADDR_LIMIT);

  // write decodes, all qualified by the clock enable
  // reads change no state, so only the writes need decoding
  assign wr_low  = CLK_EN && REG_WR && (REG_ADDR == OLP_OFS_ADDR_LOW);
  assign wr_high = CLK_EN && REG_WR && (REG_ADDR == OLP_OFS_ADDR_HIGH);
  assign wr_byte = CLK_EN && REG_WR && (REG_ADDR == OLP_OFS_WRITE);

  // low address byte, full 8 bits held
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      addr_low <= OLP_RST_BYTE;
    end else if (wr_low) begin
      addr_low <= REG_WDATA;
    end
  end

  // high address keeps two bits, upper six dropped
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      addr_high <= OLP_RST_HIGH;
    end else if (wr_high) begin
      addr_high <= REG_WDATA[OLP_HIGH_W-1:0];
    end
  end

  // ***************************************************************
  // pattern memory
  // ***************************************************************
  // flip-flop storage: the player and the host fetch read any word in
  // the same cycle without arbitration, traded against area
  logic [OLP_WORD_W-1:0] mem [WORDS];

  // one word register per entry, byte-lane writes
  // data register write lands at the held address
  // each write is independent, any order works
  // every byte starts at zero after reset
  for (genvar w = 0; w < WORDS; w++) begin : g_word
    always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
        mem[w] <= '0;
      end else if (wr_byte && host_in_range && host_word == OLP_IDX_W'(w)) begin
        mem[w][host_lane*OLP_BYTE_W +: OLP_BYTE_W] <= REG_WDATA;
      end
    end
  end

  // ***************************************************************
  // readback fetch and read port
  // ***************************************************************

  // any address write arms a fetch on the next cycle
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      fetch_pend <= 1'b0;
    end else if (CLK_EN) begin
      fetch_pend <= wr_low || wr_high;
    end
  end

  // readback only loads from a fetch, never a host write
  // the fetch waits a cycle so it sees the updated address
  // a data write leaves readback alone; rewrite an address to refetch
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      readback <= OLP_RST_BYTE;
    end else if (CLK_EN && fetch_pend) begin
      if (host_in_range) begin
        readback <= mem[host_word][host_lane*OLP_BYTE_W +: OLP_BYTE_W];
      end else begin
        readback <= OLP_RST_BYTE;
      end
    end
  end

  // register read port; write-only and unmapped offsets read zero
  // the answer stands from the edge after the strobe until the next read
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      REG_RDATA <= '0;
    end else if (CLK_EN && REG_RD) begin
      case (REG_ADDR)
        OLP_OFS_ADDR_LOW:  REG_RDATA <= addr_low;
        OLP_OFS_ADDR_HIGH: REG_RDATA <= {{(OLP_BYTE_W-OLP_HIGH_W){1'b0}}, addr_high};
        OLP_OFS_READBACK:  REG_RDATA <= readback;
        default:           REG_RDATA <= '0;
      endcase
    end
  end

  // ***************************************************************
  // playback sequencer
  // ***************************************************************
  // train position
  olp_state_t            state;
  logic [OLP_IDX_W-1:0]  play_idx;
  logic [1:0]            train_num;
  logic                  first_word;
  logic                  bunch_word;

  // slot timing
  logic [DIV_W-1:0]      div_cnt;
  logic                  slot;

  // beam input edges
  logic                  gap_d;
  logic                  b0_d;
  logic                  b0_rise;
  logic                  gap_rise;
  logic                  gap_fall;

  olp_stream_if #(.WIDTH(ELEM_W)) fill_s ();
  olp_stream_if #(.WIDTH(ELEM_W)) drain_s ();

  // ***************************************************************
  // beam timing edges
  // ***************************************************************

  // inputs are synchronous, so edges come from one delay stage
  // reset leaves both at the idle low level, so no false edge follows
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      gap_d <= 1'b0;
      b0_d  <= 1'b0;
    end else if (CLK_EN) begin
      gap_d <= ABORT_GAP_IN;
      b0_d  <= BUNCH_ZERO_MARKER_IN;
    end
  end

  // rising and falling edges of the beam inputs
  assign b0_rise  = BUNCH_ZERO_MARKER_IN && !b0_d;
  assign gap_rise = ABORT_GAP_IN && !gap_d;
  assign gap_fall = !ABORT_GAP_IN && gap_d;

  // ***************************************************************
  // word slot timing
  // ***************************************************************

  // 22 ns slot divider; a full fifo stalls the slot so no word is lost
  // at one cycle per slot it idles at zero; it stays so that a faster
  // clock needs only the package constant changed
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      div_cnt <= '0;
    end else if (CLK_EN && fill_s.ready) begin
      div_cnt <= (div_cnt == DIV_LAST) ? '0 : div_cnt + 1'b1;
    end
  end

  // a slot is due when the divider wraps and the fifo has room
  assign slot = fill_s.ready && (div_cnt == DIV_LAST);

  // ***************************************************************
  // train sequencer
  // ***************************************************************

  // a train ends by holding the last word, not by wrapping, so a late
  // gap still shows word 215
  // runs from reset release, no start command
  // bunch zero restarts, gap holds, gap end rezeroes
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      state     <= OLP_TRAIN;
      play_idx  <= '0;
      train_num <= '0;
    end else if (CLK_EN) begin
      if (b0_rise) begin
        // bunch zero wins over any gap edge
        state     <= OLP_TRAIN;
        play_idx  <= '0;
        train_num <= '0;
      end else begin
        case (state)
          OLP_TRAIN: begin
            if (gap_rise) begin
              state    <= OLP_GAP;
              play_idx <= OLP_LAST_WORD;
            end else if (slot && play_idx != OLP_LAST_WORD) begin
              // one word per slot up to 215
              play_idx <= play_idx + 1'b1;
            end
          end
          OLP_GAP: begin
            // index stays on the last word until the gap ends
            if (gap_fall) begin
              state    <= OLP_TRAIN;
              play_idx <= '0;
              // next of three trains in the period
              train_num <= (train_num == 2'(OLP_TRAINS - 1)) ? '0 : train_num + 1'b1;
            end
          end
          default: begin
            // unused encoding: restart the train
            state    <= OLP_TRAIN;
            play_idx <= '0;
          end
        endcase
      end
    end
  end

  // bunch zero marks only word 0 of the first train
  assign first_word   = (play_idx == '0);
  assign bunch_word   = first_word && (train_num == '0);

  // markers travel with the word: first word, bunch zero
  assign fill_s.valid = CLK_EN && slot;
  assign fill_s.data  = {bunch_word, first_word, mem[play_idx]};

  // ***************************************************************
  // output fifo
  // ***************************************************************

  // eight deep so a short stall of the far side is absorbed; once full
  // the slot stops, so the train resumes with no word skipped
  olp_fifo #(
    .WIDTH (ELEM_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk   (CLK_SYS),
    .rst   (RESET),
    .ce    (CLK_EN),
    .in_s  (fill_s.snk),
    .out_s (drain_s.src)
  );

  // the far side's ready drains the fifo directly
  assign drain_s.ready = PAT_READY;

  // ***************************************************************
  // output stage
  // ***************************************************************

  // markers fall with the strobe, but the word stands until the next
  // delivery so the far side may sample it late
  // strobe pulses once per delivered word, fixed latency
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      PAT_DATA              <= '0;
      PAT_STROBE            <= 1'b0;
      PAT_FIRST_WORD_MARKER <= 1'b0;
      PAT_BUNCH_ZERO_MARKER <= 1'b0;
    end else if (CLK_EN) begin
      if (drain_s.valid && PAT_READY) begin
        PAT_DATA              <= drain_s.data[OLP_WORD_W-1:0];
        PAT_STROBE            <= 1'b1;
        PAT_FIRST_WORD_MARKER <= drain_s.data[OLP_WORD_W];
        PAT_BUNCH_ZERO_MARKER <= drain_s.data[OLP_WORD_W+1];
      end else begin
        PAT_STROBE            <= 1'b0;
        PAT_FIRST_WORD_MARKER <= 1'b0;
        PAT_BUNCH_ZERO_MARKER <= 1'b0;
      end
    end
  end

endmodule : olp_loopback_pattern_player

//--- olp_player_checker.sv
// timing checks on the loopback pattern player ports
`timescale 1ns/10ps
module olp_player_checker
  import olp_pkg::*;
#(
  parameter int WORDS      = OLP_WORDS,
  parameter int FIFO_DEPTH = OLP_FIFO_DEPTH
) (
  // clock and reset
  input wire logic        CLK_SYS,
  input wire logic        RESET,
  input wire logic        CLK_EN,
  // register port
  input wire logic [7:0]  REG_ADDR,
  input wire logic [7:0]  REG_WDATA,
  input wire logic        REG_WR,
  input wire logic        REG_RD,
  input wire logic [7:0]  REG_RDATA,
  // beam timing
  input wire logic        BUNCH_ZERO_MARKER_IN,
  input wire logic        ABORT_GAP_IN,
  // pattern link
  input wire logic        PAT_READY,
  input wire logic [31:0] PAT_DATA,
  input wire logic        PAT_STROBE,
  input wire logic        PAT_FIRST_WORD_MARKER,
  input wire logic        PAT_BUNCH_ZERO_MARKER
);
  // ***************************************************************
  // properties
  // ***************************************************************
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  property p_strobe_ready; PAT_STROBE |-> $past(PAT_READY); endproperty
  property p_first_strobe; PAT_FIRST_WORD_MARKER |-> PAT_STROBE; endproperty
  property p_bz_first; PAT_BUNCH_ZERO_MARKER |-> PAT_FIRST_WORD_MARKER; endproperty
  // fifo backlog plus pipeline bounds the latency
  property p_bz_latency;
    $rose(BUNCH_ZERO_MARKER_IN) && PAT_READY |-> ##[1:12] PAT_BUNCH_ZERO_MARKER;
  endproperty
  property p_gap_restart;
    $fell(ABORT_GAP_IN) && PAT_READY |-> ##[1:12] PAT_FIRST_WORD_MARKER;
  endproperty
  property p_rdata_stable; !REG_RD |=> $stable(REG_RDATA); endproperty
  property p_high_read;
    REG_RD && CLK_EN && REG_ADDR == OLP_OFS_ADDR_HIGH |=> REG_RDATA[7:2] == 6'h00;
  endproperty
  property p_wo_read; REG_RD && CLK_EN && REG_ADDR == OLP_OFS_WRITE |=> REG_RDATA == 8'h00; endproperty
  property p_data_holds; !PAT_STROBE |-> $stable(PAT_DATA); endproperty
  a_strobe_ready: assert property (p_strobe_ready) else $error("strobe without ready");
  a_first_strobe: assert property (p_first_strobe) else $error("first marker without strobe");
  a_bz_first: assert property (p_bz_first) else $error("bunch marker off first word");
  a_bz_latency: assert property (p_bz_latency) else $error("bunch marker late");
  a_gap_restart: assert property (p_gap_restart) else $error("no restart after gap");
  a_rdata_stable: assert property (p_rdata_stable) else $error("read data moved");
  a_high_read: assert property (p_high_read) else $error("high address upper bits set");
  a_wo_read: assert property (p_wo_read) else $error("write register readable");
  a_data_holds: assert property (p_data_holds) else $error("word changed between strobes");
  c_bz: cover property (PAT_BUNCH_ZERO_MARKER);
  c_gap: cover property ($fell(ABORT_GAP_IN));
  c_rd: cover property (REG_RD && REG_ADDR == OLP_OFS_READBACK);
endmodule : olp_player_checker

bind olp_loopback_pattern_player olp_player_checker #(.WORDS(WORDS), .FIFO_DEPTH(FIFO_DEPTH)) u_chk (
  .CLK_SYS(CLK_SYS), .RESET(RESET), .CLK_EN(CLK_EN), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
  .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .BUNCH_ZERO_MARKER_IN(BUNCH_ZERO_MARKER_IN),
  .ABORT_GAP_IN(ABORT_GAP_IN), .PAT_READY(PAT_READY), .PAT_DATA(PAT_DATA), .PAT_STROBE(PAT_STROBE),
  .PAT_FIRST_WORD_MARKER(PAT_FIRST_WORD_MARKER), .PAT_BUNCH_ZERO_MARKER(PAT_BUNCH_ZERO_MARKER));

//--- olp_sink_model.sv
// downstream card model: takes pattern words and can hold off
`timescale 1ns/10ps
module olp_sink_model (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // pattern link
  input wire logic        strobe,
  input wire logic [31:0] data,
  input wire logic        hold_off,
  output logic            ready,
  // record of delivery
  output logic [31:0]     last_word,
  output logic [15:0]     word_count
);
  // level ready, dropped only when the bench commands a stall
  assign ready = !hold_off;
  // count every strobe so a lost or extra word shows up
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      last_word  <= 32'h0;
      word_count <= 16'h0;
    end else if (strobe) begin
      last_word  <= data;
      word_count <= word_count + 16'h1;
    end
  end
endmodule : olp_sink_model

//--- olp_tb.sv
// self-checking bench for the loopback pattern player
`timescale 1ns/10ps
module tb;
  import olp_pkg::*;
  logic        clk_sys, rst, clk_en, reg_wr, reg_rd, bz_in, gap_in, pat_ready, hold_off;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic [31:0] pat_data, last_word;
  logic        pat_strobe, pat_first, pat_bz;
  logic [15:0] word_count, cnt;
  int          num_errors, cmp_count;

  olp_loopback_pattern_player u_dut (.CLK_SYS(clk_sys), .RESET(rst), .CLK_EN(clk_en), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .BUNCH_ZERO_MARKER_IN(bz_in),
    .ABORT_GAP_IN(gap_in), .PAT_READY(pat_ready), .PAT_DATA(pat_data), .PAT_STROBE(pat_strobe),
    .PAT_FIRST_WORD_MARKER(pat_first), .PAT_BUNCH_ZERO_MARKER(pat_bz));
  olp_sink_model u_sink (.clk(clk_sys), .rst(rst), .strobe(pat_strobe), .data(pat_data), .hold_off(hold_off),
    .ready(pat_ready), .last_word(last_word), .word_count(word_count));

  // ***************************************************************
  // clock and shared tasks
  // ***************************************************************
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic conclude;
    if (num_errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  // strobe held one cycle, lowered before the next request
  task automatic reg_wr_b(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys); reg_addr = a; reg_wdata = d; reg_wr = 1'b1;
    @(negedge clk_sys); reg_wr = 1'b0;
  endtask : reg_wr_b
  task automatic reg_rd_b(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk_sys); reg_addr = a; reg_rd = 1'b1;
    @(negedge clk_sys); reg_rd = 1'b0;
    check({24'h0, reg_rdata}, {24'h0, exp});
  endtask : reg_rd_b
  task automatic set_addr(input logic [9:0] a);
    reg_wr_b(OLP_OFS_ADDR_HIGH, {6'h0, a[9:8]});
    reg_wr_b(OLP_OFS_ADDR_LOW, a[7:0]);
  endtask : set_addr
  task automatic wait_marker(input logic want_bz);
    for (int i = 0; i < 40; i++) begin
      @(negedge clk_sys);
      if (want_bz ? pat_bz === 1'b1 : pat_first === 1'b1) return;
    end
    num_errors++;
    $display("CHECK FAILED at %0t got %h exp %h", $time, 1'b0, 1'b1);
    conclude();
  endtask : wait_marker

  // ***************************************************************
  // scenarios
  // ***************************************************************
  task automatic t_reset_values;
    check({31'h0, word_count !== 16'h0}, 32'h1);
    reg_rd_b(OLP_OFS_ADDR_LOW, 8'h00);
    reg_rd_b(OLP_OFS_ADDR_HIGH, 8'h00);
    reg_rd_b(OLP_OFS_READBACK, 8'h00);
    reg_rd_b(OLP_OFS_WRITE, 8'h00);
  endtask : t_reset_values
  task automatic t_byte_access;
    reg_wr_b(OLP_OFS_ADDR_HIGH, 8'hff);
    reg_rd_b(OLP_OFS_ADDR_HIGH, 8'h03);
    reg_wr_b(OLP_OFS_ADDR_LOW, 8'h5d);
    reg_rd_b(OLP_OFS_ADDR_LOW, 8'h5d);
    reg_wr_b(OLP_OFS_WRITE, 8'ha5);
    reg_wr_b(OLP_OFS_READBACK, 8'h3c);
    reg_rd_b(OLP_OFS_READBACK, 8'h00);
    reg_wr_b(OLP_OFS_ADDR_LOW, 8'h5d);
    reg_rd_b(OLP_OFS_READBACK, 8'ha5);
    reg_wr_b(OLP_OFS_ADDR_LOW, 8'h5c);
    reg_rd_b(OLP_OFS_READBACK, 8'h00);
    reg_wr_b(OLP_OFS_ADDR_LOW, 8'h60);
    reg_wr_b(OLP_OFS_WRITE, 8'h77);
    reg_wr_b(OLP_OFS_ADDR_LOW, 8'h60);
    reg_rd_b(OLP_OFS_READBACK, 8'h00);
  endtask : t_byte_access
  task automatic t_load;
    // lanes loaded highest first to show order does not matter
    for (int k = 3; k >= 0; k--) begin
      set_addr(10'(k));
      reg_wr_b(OLP_OFS_WRITE, 8'h11 * 8'(4 - k));
    end
    set_addr(10'h004);
    reg_wr_b(OLP_OFS_WRITE, 8'h55);
    set_addr(10'h002);
    reg_rd_b(OLP_OFS_READBACK, 8'h22);
  endtask : t_load
  task automatic t_playback;
    // source select and frame pulse live outside; the bench plays as if set
    @(negedge clk_sys); bz_in = 1'b1;
    @(negedge clk_sys); bz_in = 1'b0;
    wait_marker(1'b1);
    check(pat_data, 32'h11223344);
    @(negedge clk_sys);
    check({pat_strobe, pat_first, pat_data[29:0]}, {2'b10, 30'h55});
    check(last_word, 32'h11223344);
    // three gaps bring the train count round to zero again
    for (int g = 1; g <= 3; g++) begin
      repeat (230) @(negedge clk_sys);
      gap_in = 1'b1;
      repeat (5) @(negedge clk_sys);
      check({pat_first, pat_data}, {1'b0, 32'h0000a500});
      gap_in = 1'b0;
      wait_marker(1'b0);
      check({pat_bz, pat_data[30:0]}, {g == 3, 31'h11223344});
    end
  endtask : t_playback
  task automatic t_stall;
    hold_off = 1'b1;
    repeat (4) @(negedge clk_sys);
    cnt = word_count;
    repeat (20) @(negedge clk_sys);
    check({16'h0, word_count}, {16'h0, cnt});
    hold_off = 1'b0;
    repeat (4) @(negedge clk_sys);
    check({31'h0, pat_strobe}, 32'h1);
    // a low clock enable must drop a register write
    clk_en = 1'b0;
    reg_wr_b(OLP_OFS_ADDR_LOW, 8'h12);
    clk_en = 1'b1;
    reg_rd_b(OLP_OFS_ADDR_LOW, 8'h02);
  endtask : t_stall
  task automatic t_second_reset;
    @(negedge clk_sys); rst = 1'b1;
    repeat (3) @(negedge clk_sys); rst = 1'b0;
    set_addr(10'h000);
    reg_rd_b(OLP_OFS_READBACK, 8'h00);
  endtask : t_second_reset

  // ***************************************************************
  // main sequence
  // ***************************************************************
  initial begin
    num_errors = 0; cmp_count = 0;
    rst = 1'b1; clk_en = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 8'h00;
    bz_in = 1'b0; gap_in = 1'b0; hold_off = 1'b0;
    repeat (20) @(negedge clk_sys);
    rst = 1'b0;
    repeat (6) @(negedge clk_sys);
    t_reset_values();
    t_byte_access();
    t_load();
    t_playback();
    t_stall();
    t_second_reset();
    conclude();
  end
endmodule : tb
